/* File: design/dma_ctrl.sv */
// Linked-descriptor DMA controller: register slave, shared transfer engine, staging FIFO.
// Assumes a memory master port with AXI-style handshakes and level pacing lines from peripherals.
//
// Contract
// - Sixteen channels, each steered onto one of three system buses.
// - A channel learns its transfer only by fetching a descriptor from memory.
// - After a descriptor finishes, the pointed-to descriptor is loaded and run.
// - Read bursts take their length from the descriptor burst field.
// - Writes are single beats, or two-beat bursts when wide writes fit.
// - A low pacing request holds back the channel's data reads; its descriptor fetches still go out.
// - Peripheral urgency raises the bus priority level driven out.
// - Pacing line to channel mapping is programmable per descriptor.
// - Byte-sized lengths are packed into as few full-word accesses as possible.
// - A top enable register keeps each cleared channel from being picked out of idle; a step already under way still runs on to idle.
// - Channels zero to fourteen sit 0x100 apart from the primary base.
// - Channel fifteen decodes at its own base, offset zero.
// - Prefetch mode reads data and writes nothing.
// - Reduced channels lack stride and wide writes but keep the common map.
// - Descriptors are eight words on a 256-bit aligned address.
// - Writing the descriptor pointer then setting active starts the channel.
// - A zero next pointer is copied in, active clears, channel stops.
`timescale 1ns/1ps

module dma_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] count;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
	} fifo_state_t;

	fifo_state_t state_reg;
	fifo_state_t state_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop;

	// Honest full and empty from the fill count
	assign in_ready = state_reg.count != (AW+1)'(DEPTH);
	assign out_valid = state_reg.count != '0;
	assign out_data = mem[state_reg.rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointer and count update
	always_comb begin
		state_next = state_reg;
		if (push) begin
			state_next.wp = state_reg.wp + 1'b1;
		end
		if (pop) begin
			state_next.rp = state_reg.rp + 1'b1;
		end
		state_next.count = state_reg.count + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Storage, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem[state_reg.wp] <= in_data;
		end
	end
endmodule

module dma_ctrl import dma_pkg::*; (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	// Avalon-MM register slave
	input wire logic [31:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Memory master, read side
	output axi_addr_t M_AR,
	output logic M_ARVALID,
	input wire logic M_ARREADY,
	input wire logic [31:0] M_RDATA,
	input wire logic M_RVALID,
	input wire logic M_RLAST,
	output logic M_RREADY,
	// Memory master, write side
	output axi_addr_t M_AW,
	output logic M_AWVALID,
	input wire logic M_AWREADY,
	output logic [31:0] M_WDATA,
	output logic [3:0] M_WSTRB,
	output logic M_WLAST,
	output logic M_WVALID,
	input wire logic M_WREADY,
	input wire logic M_BVALID,
	output logic M_BREADY,
	output logic [1:0] M_BUS_SEL,
	// Peripheral pacing
	input wire logic [31:0] PACE_REQ,
	input wire logic [31:0] PACE_PANIC
);
	localparam engine_state_t RESET_STATE = '{ch: '0, enable: `ENABLE_RESET, fsm: S_IDLE, cur: '0, rr: '0,
		beat: '0, cnt: '0, ack: 1'b0, rdata: '0};

	engine_state_t state_reg;
	engine_state_t state_next;
	chan_t cur_ch;
	logic [4:0] map;
	logic panic;
	logic prefetch;
	logic reduced;
	logic [4:0] burst_p1;
	logic [31:0] words_left;
	logic [4:0] chunk;
	logic [4:0] chunk_m1;
	logic two_beat;
	logic [3:0] last_strb;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic bus_req;
	logic hit_ch;
	logic hit_enable;
	logic [3:0] bus_ch;
	logic [7:0] bus_ofs;
	logic found;
	logic [3:0] idx;
	logic [3:0] pick;

	// Pacing line gate for a channel; line zero means unpaced
	function automatic logic pace_of(input logic [31:0] info, input logic [31:0] req);
		logic [4:0] line;
		line = info[`TI_MAP_LO +: 5];
		return (line == 5'h00) | req[line];
	endfunction

	// Byte-enable merge for writable registers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Current channel view
	assign cur_ch = state_reg.ch[state_reg.cur];
	assign map = cur_ch.info[`TI_MAP_LO +: 5];
	assign panic = (map != 5'h00) & PACE_PANIC[map];
	assign prefetch = cur_ch.info[`TI_PREFETCH];
	assign reduced = state_reg.cur >= `REDUCED_FIRST;
	assign burst_p1 = {1'b0, cur_ch.info[`TI_BURST_LO +: 4]} + 5'h01;
	assign words_left = (cur_ch.len + 32'h00000003) >> 2;
	assign chunk = (words_left > {27'h0000000, burst_p1}) ? burst_p1 : words_left[4:0];
	assign chunk_m1 = chunk - 5'h01;
	assign two_beat = (state_reg.cnt >= 5'h02) & ~cur_ch.dst[2] & ~reduced & (cur_ch.len > 32'h00000004);
	assign last_strb = (cur_ch.len >= 32'h00000004) ? 4'hf : (4'hf >> (3'h4 - {1'b0, cur_ch.len[1:0]}));

	// Memory master outputs
	assign M_ARVALID = (state_reg.fsm == S_FETCH_AR) | (state_reg.fsm == S_RD_AR);
	assign M_AR.addr = (state_reg.fsm == S_FETCH_AR) ? {cur_ch.desc[31:5], 5'h00} : {cur_ch.src[31:2], 2'h0};
	assign M_AR.len = (state_reg.fsm == S_FETCH_AR) ? `FETCH_LEN : chunk_m1[3:0];
	assign M_AR.qos = panic ? `QOS_PANIC : `QOS_NORMAL;
	assign M_AWVALID = state_reg.fsm == S_WR_AW;
	assign M_AW.addr = {cur_ch.dst[31:2], 2'h0};
	assign M_AW.len = two_beat ? 4'h1 : 4'h0;
	assign M_AW.qos = M_AR.qos;
	assign M_WVALID = (state_reg.fsm == S_WR_W) & fifo_out_valid;
	assign M_WLAST = state_reg.beat == 3'h0;
	assign M_WSTRB = last_strb;
	assign M_BREADY = state_reg.fsm == S_WR_B;
	assign M_RREADY = ((state_reg.fsm == S_RD_R) & (prefetch | fifo_in_ready)) | (state_reg.fsm == S_FETCH_R);
	assign M_BUS_SEL = (cur_ch.info[`TI_BUS_LO +: 2] > `LAST_BUS) ? `LAST_BUS : cur_ch.info[`TI_BUS_LO +: 2];
	assign fifo_in_valid = (state_reg.fsm == S_RD_R) & M_RVALID & ~prefetch;
	assign fifo_out_ready = (state_reg.fsm == S_WR_W) & M_WREADY;

	// Register slave: one wait cycle, then the answer
	assign bus_req = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = bus_req & ~state_reg.ack;
	assign AVS_READDATA = state_reg.rdata;
	assign hit_ch = ((AVS_ADDRESS[31:12] == 20'(`PRIMARY_BASE >> 12)) & (AVS_ADDRESS[11:8] != `DETACHED_CH))
		| (AVS_ADDRESS[31:8] == 24'(`DETACHED_BASE >> 8));
	assign bus_ch = (AVS_ADDRESS[31:8] == 24'(`DETACHED_BASE >> 8)) ? `DETACHED_CH : AVS_ADDRESS[11:8];
	assign bus_ofs = AVS_ADDRESS[7:0];
	assign hit_enable = AVS_ADDRESS == (`PRIMARY_BASE | {20'h00000, `ENABLE_OFS});

	dma_fifo #(
		.WIDTH(`DATA_W),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(M_RDATA),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(M_WDATA)
	);

	// Next state: bus access first, engine after it so hardware sets win
	always_comb begin
		state_next = state_reg;
		found = 1'b0;
		pick = state_reg.rr;
		idx = state_reg.rr;
		state_next.ack = bus_req & ~state_reg.ack;
		if (AVS_READ & ~state_reg.ack) begin
			state_next.rdata = 32'h00000000;
			if (hit_enable) begin
				state_next.rdata = {16'h0000, state_reg.enable};
			end else if (hit_ch) begin
				unique case (bus_ofs)
					`OFS_CS: state_next.rdata = {28'h0000000, ~pace_of(state_reg.ch[bus_ch].info, PACE_REQ),
						state_reg.ch[bus_ch].loaded, state_reg.ch[bus_ch].done, state_reg.ch[bus_ch].active};
					`OFS_DESC: state_next.rdata = state_reg.ch[bus_ch].desc;
					`OFS_INFO: state_next.rdata = state_reg.ch[bus_ch].info;
					`OFS_SRC: state_next.rdata = state_reg.ch[bus_ch].src;
					`OFS_DST: state_next.rdata = state_reg.ch[bus_ch].dst;
					`OFS_LEN: state_next.rdata = state_reg.ch[bus_ch].len;
					`OFS_STRIDE: state_next.rdata = state_reg.ch[bus_ch].stride;
					`OFS_NEXT: state_next.rdata = state_reg.ch[bus_ch].next;
					`OFS_DEBUG: state_next.rdata = {28'h0000000, state_reg.cur ^ bus_ch};
					default: state_next.rdata = 32'h00000000;
				endcase
			end
		end
		// Writes land on the edge that completes the access
		if (AVS_WRITE & state_reg.ack) begin
			if (hit_enable) begin
				state_next.enable = 16'(merge({16'h0000, state_reg.enable}, AVS_WRITEDATA, AVS_BYTEENABLE));
			end else if (hit_ch) begin
				unique case (bus_ofs)
					`OFS_CS: begin
						if (AVS_BYTEENABLE[3] & AVS_WRITEDATA[`CS_ABORT]) begin
							state_next.ch[bus_ch].active = 1'b0;
							state_next.ch[bus_ch].loaded = 1'b0;
						end else if (AVS_BYTEENABLE[0]) begin
							state_next.ch[bus_ch].active = AVS_WRITEDATA[`CS_ACTIVE];
							if (AVS_WRITEDATA[`CS_END]) begin
								state_next.ch[bus_ch].done = 1'b0;
							end
						end
					end
					`OFS_DESC: begin
						state_next.ch[bus_ch].desc = merge(state_reg.ch[bus_ch].desc, AVS_WRITEDATA, AVS_BYTEENABLE);
						state_next.ch[bus_ch].loaded = 1'b0;
					end
					`OFS_NEXT: state_next.ch[bus_ch].next = merge(state_reg.ch[bus_ch].next, AVS_WRITEDATA,
						AVS_BYTEENABLE);
					default: begin
					end
				endcase
			end
		end
		// Transfer engine
		unique case (state_reg.fsm)
			S_IDLE: begin
				for (int i = 0; i < `NUM_CH; i++) begin
					idx = state_reg.rr + 4'(i);
					if (!found && state_reg.ch[idx].active && state_reg.enable[idx]
						&& (!state_reg.ch[idx].loaded || state_reg.ch[idx].len == 32'h00000000
						|| pace_of(state_reg.ch[idx].info, PACE_REQ))) begin
						found = 1'b1;
						pick = idx;
					end
				end
				if (found) begin
					state_next.cur = pick;
					state_next.rr = pick + 4'h1;
					if (!state_reg.ch[pick].loaded) begin
						state_next.fsm = S_FETCH_AR;
					end else if (state_reg.ch[pick].len == 32'h00000000) begin
						state_next.fsm = S_NEXT;
					end else begin
						state_next.fsm = S_RD_AR;
					end
				end
			end
			S_FETCH_AR: begin
				state_next.beat = 3'h0;
				if (M_ARREADY) begin
					state_next.fsm = S_FETCH_R;
				end
			end
			S_FETCH_R: begin
				if (M_RVALID) begin
					state_next.beat = state_reg.beat + 3'h1;
					case (state_reg.beat)
						3'h0: state_next.ch[state_reg.cur].info = M_RDATA;
						3'h1: state_next.ch[state_reg.cur].src = M_RDATA;
						3'h2: state_next.ch[state_reg.cur].dst = M_RDATA;
						3'h3: state_next.ch[state_reg.cur].len = M_RDATA;
						3'h4: state_next.ch[state_reg.cur].stride = reduced ? 32'h00000000 : M_RDATA;
						3'h5: state_next.ch[state_reg.cur].next = M_RDATA;
						default: begin
						end
					endcase
					if (M_RLAST) begin
						state_next.ch[state_reg.cur].loaded = 1'b1;
						state_next.fsm = S_IDLE;
					end
				end
			end
			S_RD_AR: begin
				if (M_ARREADY) begin
					state_next.cnt = chunk;
					state_next.ch[state_reg.cur].src = cur_ch.src + {25'h0000000, chunk, 2'h0};
					state_next.fsm = S_RD_R;
				end
			end
			S_RD_R: begin
				if (M_RVALID && M_RREADY) begin
					if (prefetch) begin
						state_next.ch[state_reg.cur].len = (cur_ch.len > 32'h00000004) ? cur_ch.len - 32'h00000004
							: 32'h00000000;
					end
					if (M_RLAST) begin
						state_next.fsm = prefetch ? S_IDLE : S_WR_AW;
					end
				end
			end
			S_WR_AW: begin
				if (M_AWREADY) begin
					state_next.beat = two_beat ? 3'h1 : 3'h0;
					state_next.fsm = S_WR_W;
				end
			end
			S_WR_W: begin
				if (M_WVALID && M_WREADY) begin
					state_next.ch[state_reg.cur].len = (cur_ch.len > 32'h00000004) ? cur_ch.len - 32'h00000004
						: 32'h00000000;
					state_next.ch[state_reg.cur].dst = cur_ch.dst + 32'h00000004;
					state_next.cnt = state_reg.cnt - 5'h01;
					state_next.beat = state_reg.beat - 3'h1;
					if (state_reg.beat == 3'h0) begin
						state_next.fsm = S_WR_B;
					end
				end
			end
			S_WR_B: begin
				if (M_BVALID) begin
					state_next.fsm = (state_reg.cnt == 5'h00) ? S_IDLE : S_WR_AW;
				end
			end
			S_NEXT: begin
				state_next.ch[state_reg.cur].desc = cur_ch.next;
				state_next.ch[state_reg.cur].loaded = 1'b0;
				if (cur_ch.next == 32'h00000000) begin
					state_next.ch[state_reg.cur].active = 1'b0;
					state_next.ch[state_reg.cur].done = 1'b1;
					state_next.fsm = S_IDLE;
				end else begin
					state_next.fsm = S_FETCH_AR;
				end
			end
		endcase
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			state_reg <= RESET_STATE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Checks on the engine and the slave
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);

	pace_gate_a: assert property ($rose(state_reg.fsm == S_RD_AR)
		|-> map == 5'h00 || (($past(PACE_REQ) >> map) & 32'h1) != 32'h0)
		else $error("Read issued while pacing request low");
	panic_qos_a: assert property (M_ARVALID && panic |-> M_AR.qos == `QOS_PANIC)
		else $error("Urgency did not raise priority");
	fetch_shape_a: assert property (state_reg.fsm == S_FETCH_AR |-> M_AR.len == 4'h7 && M_AR.addr[4:0] == 5'h00)
		else $error("Descriptor fetch not eight aligned words");
	read_burst_a: assert property (state_reg.fsm == S_RD_AR |-> {1'b0, M_AR.len} < burst_p1)
		else $error("Read burst longer than descriptor allows");
	write_beats_a: assert property (M_AWVALID |-> M_AW.len <= 4'h1 && !(reduced && M_AW.len != 4'h0))
		else $error("Write burst too long");
	chain_next_a: assert property (state_reg.fsm == S_NEXT && cur_ch.next != 0
		|=> state_reg.fsm == S_FETCH_AR && cur_ch.desc == $past(cur_ch.next))
		else $error("Next descriptor not followed");
	stop_zero_a: assert property (state_reg.fsm == S_NEXT && cur_ch.next == 0
		|=> !cur_ch.active && cur_ch.desc == 32'h00000000 && state_reg.fsm == S_IDLE)
		else $error("Channel did not stop on zero pointer");
	prefetch_nowr_a: assert property (M_AWVALID |-> !prefetch)
		else $error("Prefetch wrote to memory");
	enable_gate_a: assert property ($rose(M_ARVALID) |-> state_reg.enable[state_reg.cur])
		else $error("Disabled channel used the bus");
	slave_answer_a: assert property (bus_req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("Slave answer late");

	chain_c: cover property (state_reg.fsm == S_NEXT && cur_ch.next != 0);
	stop_c: cover property (state_reg.fsm == S_NEXT && cur_ch.next == 0);
	prefetch_c: cover property (state_reg.fsm == S_RD_R && prefetch && M_RLAST);
	two_beat_c: cover property (M_AWVALID && M_AWREADY && M_AW.len == 4'h1);
endmodule

/* File: design/dma_params.svh */
// Constants of the linked-descriptor DMA controller: map offsets, field positions, reset values.
// Assumes inclusion by bare name from the package and the two test files.
`ifndef DMA_PARAMS_SVH
`define DMA_PARAMS_SVH

// Channel count and data path
`define NUM_CH 16
`define DATA_W 32
`define FIFO_DEPTH 16
// Register map placement
`define PRIMARY_BASE 32'h7e007000
`define DETACHED_BASE 32'h7ee05000
`define ENABLE_OFS 12'hff0
`define DETACHED_CH 4'hf
// Per-channel register offsets
`define OFS_CS 8'h00
`define OFS_DESC 8'h04
`define OFS_INFO 8'h08
`define OFS_SRC 8'h0c
`define OFS_DST 8'h10
`define OFS_LEN 8'h14
`define OFS_STRIDE 8'h18
`define OFS_NEXT 8'h1c
`define OFS_DEBUG 8'h20
// Control and status bits
`define CS_ACTIVE 0
`define CS_END 1
`define CS_LOADED 2
`define CS_WAITING 3
`define CS_ABORT 31
// Transfer information fields
`define TI_PREFETCH 26
`define TI_BUS_LO 24
`define TI_MAP_LO 16
`define TI_BURST_LO 12
// Reset values and fixed figures
`define ENABLE_RESET 16'hffff
`define REDUCED_FIRST 4'h7
`define FETCH_LEN 4'h7
`define QOS_NORMAL 4'h0
`define QOS_PANIC 4'hf
`define LAST_BUS 2'h2

`endif

/* File: design/dma_pkg.sv */
// Types shared by the DMA controller: channel state, engine states, bus address beats.
// Assumes dma_params.svh is on the include path.
package dma_pkg;
	`include "dma_params.svh"

	// Engine sequencing
	typedef enum logic [3:0] {
		S_IDLE, S_FETCH_AR, S_FETCH_R, S_RD_AR, S_RD_R, S_WR_AW, S_WR_W, S_WR_B, S_NEXT
	} fsm_t;

	// One channel: control bits and the loaded descriptor words
	typedef struct packed {
		logic active;
		logic done;
		logic loaded;
		logic [31:0] desc;
		logic [31:0] info;
		logic [31:0] src;
		logic [31:0] dst;
		logic [31:0] len;
		logic [31:0] stride;
		logic [31:0] next;
	} chan_t;

	// Address phase of a memory bus request
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0] len;
		logic [3:0] qos;
	} axi_addr_t;

	// Whole controller state
	typedef struct packed {
		chan_t [`NUM_CH-1:0] ch;
		logic [`NUM_CH-1:0] enable;
		fsm_t fsm;
		logic [3:0] cur;
		logic [3:0] rr;
		logic [2:0] beat;
		logic [4:0] cnt;
		logic ack;
		logic [31:0] rdata;
	} engine_state_t;
endpackage

/* File: test/dma_mem_model.sv */
// Memory stand-in for the DMA master port: one read stream and one write stream.
// Assumes the bench preloads mem and sets the stall count between tests.
`timescale 1ns/1ps
`include "dma_params.svh"

module dma_mem_model import dma_pkg::*; (
	// Clock and stall setting
	input wire logic clk,
	input wire logic [3:0] stall,
	// Read side
	input wire axi_addr_t ar,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic rvalid,
	output logic rlast,
	input wire logic rready,
	// Write side
	input wire axi_addr_t aw,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic bvalid,
	input wire logic bready
);
	logic [31:0] mem [int unsigned];
	logic [15:0] ar_lens = 16'h0;
	logic [15:0] aw_lens = 16'h0;
	int aw_count = 0;
	logic panic_seen = 1'b0;
	axi_addr_t a, w;
	logic [31:0] v;

	// Unwritten words read back as their inverted word index
	function automatic logic [31:0] peek(logic [31:0] ad);
		return mem.exists(ad >> 2) ? mem[ad >> 2] : ~(ad >> 2);
	endfunction

	// Read stream: address after a stall, then len+1 beats; data scrambled when idle
	initial begin
		arready = 1'b0;
		rvalid = 1'b0;
		rlast = 1'b0;
		rdata = 32'h0;
		forever begin
			@(posedge clk);
			if (arvalid) begin
				repeat (stall) @(posedge clk);
				arready <= 1'b1;
				a = ar;
				@(posedge clk);
				arready <= 1'b0;
				ar_lens[a.len] = 1'b1;
				if (a.qos == `QOS_PANIC) panic_seen = 1'b1;
				for (int i = 0; i <= a.len; i++) begin
					rdata <= peek(a.addr + 4 * i);
					rvalid <= 1'b1;
					rlast <= (i == a.len);
					do @(posedge clk); while (!rready);
				end
				rvalid <= 1'b0;
				rlast <= 1'b0;
				rdata <= ~rdata;
			end
		end
	end

	// Write stream: address, len+1 strobed beats, then one response
	initial begin
		awready = 1'b0;
		wready = 1'b0;
		bvalid = 1'b0;
		forever begin
			@(posedge clk);
			if (awvalid) begin
				repeat (stall) @(posedge clk);
				awready <= 1'b1;
				w = aw;
				@(posedge clk);
				awready <= 1'b0;
				wready <= 1'b1;
				aw_lens[w.len] = 1'b1;
				aw_count++;
				if (w.qos == `QOS_PANIC) panic_seen = 1'b1;
				for (int j = 0; j <= w.len; j++) begin
					do @(posedge clk); while (!wvalid);
					v = peek(w.addr + 4 * j);
					for (int b = 0; b < 4; b++) if (wstrb[b]) v[8 * b +: 8] = wdata[8 * b +: 8];
					mem[(w.addr >> 2) + j] = v;
				end
				wready <= 1'b0;
				bvalid <= 1'b1;
				do @(posedge clk); while (!bready);
				bvalid <= 1'b0;
			end
		end
	end
endmodule

/* File: test/dma_ctrl_bench.sv */
// Self-checking bench of the DMA controller: map, chained copy, prefetch, pacing, power enable.
// Assumes dma_mem_model on the memory port; a shadow array is the reference.
`timescale 1ns/1ps
`include "dma_params.svh"

module dma_ctrl_bench import dma_pkg::*;;
	logic CLK_SYS, RESET_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, M_ARVALID, M_ARREADY, M_RVALID, M_RLAST;
	logic M_RREADY, M_AWVALID, M_AWREADY, M_WLAST, M_WVALID, M_WREADY, M_BVALID, M_BREADY;
	logic [31:0] AVS_ADDRESS, AVS_WRITEDATA, AVS_READDATA, M_RDATA, M_WDATA, PACE_REQ, PACE_PANIC, q;
	logic [3:0] M_WSTRB, stall, beats;
	logic [1:0] M_BUS_SEL, bus_seen;
	axi_addr_t M_AR, M_AW;
	logic [31:0] shadow [int unsigned];
	logic [15:0] lfsr;
	int failures = 0;
	int comparisons = 0;

	dma_ctrl dma_ctrl_inst (.CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST), .M_AR(M_AR), .M_ARVALID(M_ARVALID), .M_ARREADY(M_ARREADY),
		.M_RDATA(M_RDATA), .M_RVALID(M_RVALID), .M_RLAST(M_RLAST), .M_RREADY(M_RREADY), .M_AW(M_AW),
		.M_AWVALID(M_AWVALID), .M_AWREADY(M_AWREADY), .M_WDATA(M_WDATA), .M_WSTRB(M_WSTRB), .M_WLAST(M_WLAST),
		.M_WVALID(M_WVALID), .M_WREADY(M_WREADY), .M_BVALID(M_BVALID), .M_BREADY(M_BREADY),
		.M_BUS_SEL(M_BUS_SEL), .PACE_REQ(PACE_REQ), .PACE_PANIC(PACE_PANIC));

	dma_mem_model dma_mem_model_inst (.clk(CLK_SYS), .stall(stall), .ar(M_AR), .arvalid(M_ARVALID),
		.arready(M_ARREADY), .rdata(M_RDATA), .rvalid(M_RVALID), .rlast(M_RLAST), .rready(M_RREADY), .aw(M_AW),
		.awvalid(M_AWVALID), .awready(M_AWREADY), .wdata(M_WDATA), .wstrb(M_WSTRB), .wvalid(M_WVALID),
		.wready(M_WREADY), .bvalid(M_BVALID), .bready(M_BREADY));

	// Free-running system clock
	initial begin
		CLK_SYS = 1'b0;
		forever #20 CLK_SYS = ~CLK_SYS;
	end

	// Bus number shown while the shared source words are requested
	always @(posedge CLK_SYS) if (M_ARVALID && M_AR.addr == 32'h4000) bus_seen <= M_BUS_SEL;

	// Last-beat flag against the burst length taken with the write address
	always @(posedge CLK_SYS) begin
		if (M_AWVALID && M_AWREADY) beats <= M_AW.len;
		if (M_WVALID && M_WREADY) begin
			check("last beat", {31'h0, beats == 4'h0}, {31'h0, M_WLAST});
			beats <= beats - 4'h1;
		end
	end

	function automatic logic [15:0] step(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Register address of a channel; channel 15 sits at its own base
	function automatic logic [31:0] ra(int ch, logic [7:0] ofs);
		return (ch == 15 ? `DETACHED_BASE : `PRIMARY_BASE + ch * 32'h100) + ofs;
	endfunction

	// One Avalon access, held until waitrequest is seen low
	task automatic bus(logic wr, logic [31:0] ad, logic [31:0] d);
		int n;
		@(posedge CLK_SYS);
		AVS_ADDRESS <= ad;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (AVS_WAITREQUEST !== 1'b0 && n < 100);
		if (n >= 100) failures++;
		q = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask

	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Random source words, kept in the shadow as well
	task automatic fill(logic [31:0] at, int n);
		for (int k = 0; k < n; k++) begin
			lfsr = step(step(lfsr));
			shadow[(at >> 2) + k] = {lfsr, ~lfsr ^ 16'h5a5a};
			dma_mem_model_inst.mem[(at >> 2) + k] = shadow[(at >> 2) + k];
		end
	endtask

	// Eight-word descriptor on an aligned address, last two words zero
	task automatic put_desc(logic [31:0] at, logic [31:0] info, src, dst, len, nxt);
		logic [31:0] w [8];
		w = '{info, src, dst, len, 32'h0, nxt, 32'h0, 32'h0};
		for (int k = 0; k < 8; k++) dma_mem_model_inst.mem[(at >> 2) + k] = w[k];
	endtask

	// Destination bytes below len hold the source when copied, else the untouched pattern
	task automatic copy_check(logic [31:0] src, dst, int len, bit copied);
		logic [31:0] e;
		for (int k = 0; k < (len + 3) / 4; k++) begin
			e = ~((dst >> 2) + k);
			for (int b = 0; b < 4; b++) if (copied && 4 * k + b < len) e[8 * b +: 8] = shadow[(src >> 2) + k][8 * b +: 8];
			check("dst word", e, dma_mem_model_inst.peek(dst + 4 * k));
		end
	endtask

	task automatic start(int ch, logic [31:0] desc);
		bus(1'b1, ra(ch, `OFS_DESC), desc);
		bus(1'b1, ra(ch, `OFS_CS), 32'h1);
	endtask

	task automatic wait_idle(int ch);
		int n;
		n = 0;
		do begin
			bus(1'b0, ra(ch, `OFS_CS), 32'h0);
			n++;
		end while (q[`CS_ACTIVE] !== 1'b0 && n < 500);
		if (n >= 500) failures++;
	endtask

	task automatic give_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog against a hung engine or bus
	initial begin
		repeat (20000) @(posedge CLK_SYS);
		failures++;
		give_verdict;
	end

	// Main sequence
	initial begin
		RESET_N = 1'b0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_ADDRESS = 32'h0;
		AVS_WRITEDATA = 32'h0;
		PACE_REQ = 32'h0;
		PACE_PANIC = 32'h0;
		stall = 4'h0;
		lfsr = 16'ha382;
		repeat (16) @(posedge CLK_SYS);
		RESET_N <= 1'b1;
		bus(1'b0, `PRIMARY_BASE + `ENABLE_OFS, 32'h0);
		check("enable", 32'h0000ffff, q);
		for (int c = 0; c < 16; c++) bus(1'b1, ra(c, `OFS_DESC), 32'h8000 + c * 32'h20);
		for (int c = 0; c < 16; c++) begin
			bus(1'b0, ra(c, `OFS_DESC), 32'h0);
			check("pointer", 32'h8000 + c * 32'h20, q);
		end
		bus(1'b0, `PRIMARY_BASE + 32'hf00, 32'h0);
		check("unmapped", 32'h0, q);
		$display("test map done");
		fill(32'h4000, 6);
		fill(32'h4100, 2);
		put_desc(32'h2000, 32'h3000, 32'h4000, 32'h5000, 22, 32'h2100);
		put_desc(32'h2100, 32'h0, 32'h4100, 32'h6000, 8, 32'h0);
		start(2, 32'h2000);
		wait_idle(2);
		copy_check(32'h4000, 32'h5000, 22, 1'b1);
		copy_check(32'h4100, 32'h6000, 8, 1'b1);
		check("status", 32'h2, q & 32'h3);
		bus(1'b0, ra(2, `OFS_DESC), 32'h0);
		check("stop pointer", 32'h0, q);
		bus(1'b0, ra(2, `OFS_SRC), 32'h0);
		check("loaded source", 32'h4100 + 32'h8, q);
		check("read burst", 32'h1, dma_mem_model_inst.ar_lens[3]);
		check("two beat write", 32'h1, dma_mem_model_inst.aw_lens[1]);
		check("calm priority", 32'h0, dma_mem_model_inst.panic_seen);
		$display("test chain done");
		dma_mem_model_inst.aw_count = 0;
		put_desc(32'h2200, 32'h0700_0000, 32'h4000, 32'h7000, 16, 32'h0);
		start(3, 32'h2200);
		wait_idle(3);
		check("prefetch writes", 32'h0, dma_mem_model_inst.aw_count);
		check("bus select", 32'h2, {30'h0, bus_seen});
		copy_check(32'h4000, 32'h7000, 16, 1'b0);
		$display("test prefetch done");
		stall <= 4'h2;
		PACE_PANIC <= 32'h20;
		put_desc(32'h2300, 32'h0005_0000, 32'h4000, 32'h8000, 12, 32'h0);
		start(4, 32'h2300);
		repeat (60) @(posedge CLK_SYS);
		bus(1'b0, ra(4, `OFS_CS), 32'h0);
		check("held active", 32'h1, q & 32'h1);
		copy_check(32'h4000, 32'h8000, 12, 1'b0);
		PACE_REQ <= 32'h20;
		wait_idle(4);
		copy_check(32'h4000, 32'h8000, 12, 1'b1);
		check("urgent priority", 32'h1, dma_mem_model_inst.panic_seen);
		$display("test pacing done");
		bus(1'b1, `PRIMARY_BASE + `ENABLE_OFS, 32'h0000ffbf);
		put_desc(32'h2400, 32'h0, 32'h4000, 32'h9000, 8, 32'h0);
		start(6, 32'h2400);
		repeat (60) @(posedge CLK_SYS);
		bus(1'b0, ra(6, `OFS_CS), 32'h0);
		check("off loaded", 32'h0, q & 32'h4);
		copy_check(32'h4000, 32'h9000, 8, 1'b0);
		$display("test power done");
		give_verdict;
	end
endmodule
